// file: rtl/fcc_pkg.sv
/*
  Constants, encodings and carrier types shared by the flash command
  controller, its timer module, the checker and the testbench.
  Assumes a single 20 MHz system clock and a byte-addressed register port.
*/
package fcc_pkg;

  // System clock and the 1 us tick used for long operations
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned TICK_HZ     = 1_000_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;

  // Operation times in their own units
  localparam int unsigned WRITE_TIME_US       = 50;
  localparam int unsigned ERASE_WRITE_TIME_MS = 20;
  localparam int unsigned MASS_ERASE_TIME_MS  = 2480;
  localparam int unsigned SIG_TIME_CYCLES     = 32778;

  // Derived counts, in 1 us ticks
  localparam int unsigned WRITE_TICKS       = WRITE_TIME_US * TICK_HZ / 1_000_000;
  localparam int unsigned ERASE_WRITE_TICKS = ERASE_WRITE_TIME_MS * 1000;
  localparam int unsigned MASS_ERASE_TICKS  = MASS_ERASE_TIME_MS * 1000;
  // Short operations, in plain clock cycles
  localparam logic [31:0] READ_CYCLES = 32'h0000_0002;
  localparam logic [31:0] PING_CYCLES = 32'h0000_0001;

  // Register offsets on the register port
  localparam logic [7:0] OFS_STATUS    = 8'h00;
  localparam logic [7:0] OFS_MODE      = 8'h04;
  localparam logic [7:0] OFS_COMMAND   = 8'h08;
  localparam logic [7:0] OFS_DATA      = 8'h0c;
  localparam logic [7:0] OFS_ADDRESS   = 8'h10;
  localparam logic [7:0] OFS_SIGNATURE = 8'h18;
  localparam logic [7:0] OFS_PERSIST   = 8'h1c;
  localparam logic [7:0] OFS_IMMED     = 8'h20;

  // Status bit positions
  localparam int unsigned STA_INT  = 3;
  localparam int unsigned STA_BUSY = 2;
  localparam int unsigned STA_FAIL = 1;
  localparam int unsigned STA_DONE = 0;

  // Mode bit positions
  localparam int unsigned MOD_IRQ_EN = 4;
  localparam int unsigned MOD_EW_EN  = 3;
  localparam int unsigned MOD_WS_HI  = 1;

  // Protection mask layout
  localparam int unsigned PROT_READ_BIT  = 31;
  localparam int unsigned PROT_GROUP_TOP = 30;

  // Reset values
  localparam logic [1:0]  WS_RST        = 2'h0;
  localparam logic [15:0] DATA_RST      = 16'h0000;
  localparam logic [15:0] ADDR_RST      = 16'h0000;
  localparam logic [23:0] SIG_RST       = 24'hffffff;
  localparam logic [31:0] PERSIST_RST   = 32'h0000_0000;
  localparam logic [31:0] IMMED_RST     = 32'h0fff_ffff;
  localparam logic [31:0] UNPROTECTED   = 32'hffff_ffff;
  localparam logic [15:0] ERASED_WORD   = 16'hffff;

  // Mass erase key values
  localparam logic [15:0] MASS_KEY_DATA = 16'h3cff;
  localparam logic [15:0] MASS_KEY_ADDR = 16'hffc3;

  // Command codes
  localparam logic [7:0] CMD_NULL     = 8'h00;
  localparam logic [7:0] CMD_READ     = 8'h01;
  localparam logic [7:0] CMD_WRITE    = 8'h02;
  localparam logic [7:0] CMD_ERASE_WR = 8'h03;
  localparam logic [7:0] CMD_VERIFY   = 8'h04;
  localparam logic [7:0] CMD_ERASE_PG = 8'h05;
  localparam logic [7:0] CMD_MASS     = 8'h06;
  localparam logic [7:0] CMD_READBACK = 8'h07;
  localparam logic [7:0] CMD_SIGN     = 8'h0b;
  localparam logic [7:0] CMD_PROTECT  = 8'h0c;
  localparam logic [7:0] CMD_PING     = 8'h0f;

  // Array geometry (16-bit words, 512-byte pages, 2 kB kernel)
  localparam logic [14:0] KERNEL_END_WORD = 15'h03ff;
  localparam logic [14:0] LAST_WORD       = 15'h7fff;
  localparam logic [7:0]  PAGE_LAST_OFS   = 8'hff;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } fcc_bus_req_type;

  // Controller states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WALK = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } fcc_state_type;

endpackage

// file: rtl/fcc_timer.sv
/*
  Operation timer: counts a loaded value down either every clock or on
  a 1 us tick from its own divider.
  Assumes load is a one-cycle pulse and the loaded count is at least one.
*/
`timescale 1ns/10ps
module fcc_timer #(
  parameter int unsigned CNT_W = 32
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // Control
  input  wire logic             load,
  input  wire logic             useTick,
  input  wire logic [CNT_W-1:0] count,
  // Status
  output logic                  expired
);
  import fcc_pkg::*;

  localparam logic [7:0] DIV_LAST = 8'(TICK_CYCLES - 1);

  logic [7:0]       div_q;     // Tick divider
  logic [CNT_W-1:0] remain_q;  // Units left
  logic             tick;      // 1 us enable pulse
  logic             step;      // Count one unit

  assign tick    = (div_q == DIV_LAST);
  assign step    = useTick ? tick : 1'b1;
  assign expired = (remain_q == '0);

  // Divider restarts with each load so the first tick is a full period
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_q <= 8'h00;
    end else if (load || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Down counter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      remain_q <= '0;
    end else if (load) begin
      remain_q <= count;
    end else if (!expired && step) begin
      remain_q <= remain_q - CNT_W'(1);
    end
  end

endmodule

// file: rtl/fcc_array.sv
/*
  Flash array storage: one word port with a synchronous read.
  Assumes at most one access per cycle; contents have no reset.
*/
`timescale 1ns/10ps
module fcc_array #(
  parameter int unsigned ADDR_W = 15,
  parameter int unsigned DATA_W = 16
) (
  // Clock
  input  wire logic              clock,
  // Access port
  input  wire logic              en,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];  // Word storage

  // Write or read one word
  always_ff @(posedge clock) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end else if (en) begin
      rdata <= mem[addr];
    end
  end

endmodule

// file: rtl/fcc_flash_command_controller.sv
/*
  Flash command controller: status, mode, command, data, address,
  signature and protection registers, and the command sequencer.
  Assumes a register port master that never strobes read and write
  together, and a peer block that reports its wait-state setting.
*/
// Local design decisions: the plain strobed port and the placing of the registers.
// Contract
// - Completion with interrupt enabled sets interrupt flag
// - Status read clears interrupt flag
// - Busy bit follows command execution
// - Failed command sets fail; read clears
// - Any completion sets done; read clears
// - Mode interrupt enable gates interrupt
// - Erase/write enable bit guards array changes
// - Wait states apply when both blocks agree
// - Null idles; read fetches addressed word
// - Write programs data, busy about 50 us
// - Erase page then program, about 20 ms
// - Verify compares word, result in fail
// - Page erase clears addressed page
// - Mass erase keeps kernel, needs key values
// - Signature over block, 32778 cycles
// - Protect saves mask once; mass erase removes
// - Ping completes and interrupts, no array work
// - Command reads 0x07 after codes 0-6
// - Mask bit 31 permits reading
// - Mask bits 30:0 permit group writes
// - Immediate mask acts at once, reset clears; code loads 0x0fff_ffff on nrst
// - Persistent mask acts after protect and reset
`timescale 1ns/10ps
module fcc_flash_command_controller #(
  parameter int unsigned ERASE_WRITE_US = fcc_pkg::ERASE_WRITE_TICKS,
  parameter int unsigned MASS_ERASE_US  = fcc_pkg::MASS_ERASE_TICKS,
  parameter int unsigned SIG_CYCLES     = fcc_pkg::SIG_TIME_CYCLES
) (
  // Clock and resets
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic                     powerOnN,
  // Register port
  input  wire fcc_pkg::fcc_bus_req_type busReq,
  output logic [31:0]                   rdata,
  // Peer block and system
  input  wire logic [1:0]               peerWaitStates,
  output logic [1:0]                    waitStates,
  output logic                          irq,
  output logic                          readAllowed
);
  import fcc_pkg::*;

  // Register state
  fcc_state_type state_q;          // Sequencer state
  logic          intFlag_q;        // Status interrupt flag
  logic          fail_q;           // Status fail flag
  logic          done_q;           // Status done flag
  logic          irqEn_q;          // Mode interrupt enable
  logic          ewEn_q;           // Mode erase/write enable
  logic [1:0]    wsReq_q;          // Mode wait-state field
  logic [1:0]    ws_q;             // Wait states in force
  logic [7:0]    cmd_q;            // Command register
  logic [15:0]   data_q;           // Data register
  logic [15:0]   addr_q;           // Address register
  logic [23:0]   sig_q;            // Signature register
  logic [31:0]   persist_q;        // Persistent mask staging
  logic [31:0]   immed_q;          // Immediate mask
  logic [31:0]   persistAct_q;     // Persistent mask in force
  logic          persistLoaded_q;  // Mask taken after reset
  logic [31:0]   saved_q;          // Saved mask, survives nrst
  logic          protUsed_q;       // Protect already run
  logic          failPend_q;       // Failure of running command
  logic [14:0]   ptr_q;            // Walk pointer
  logic [14:0]   end_q;            // Walk end
  logic          sigPend_q;        // Signature read in flight
  logic          rdPend_q;         // Read/verify in flight
  logic [31:0]   rdata_q;          // Read data
  logic          irq_q;            // Interrupt output
  logic          readAllowed_q;    // Read permission output

  // Bus decode
  wire           wrHit    = busReq.we;
  wire           rdStatus = busReq.re && (busReq.addr == OFS_STATUS);
  wire           isIdle   = (state_q == ST_IDLE);
  wire           cmdWrite = wrHit && (busReq.addr == OFS_COMMAND) && isIdle;
  wire [7:0]     code     = busReq.wdata[7:0];

  // Effective protection and its lookups
  // Combined masks
  wire [31:0]    effMask  = immed_q & persistAct_q;
  wire [4:0]     group    = addr_q[15:11];
  wire [4:0]     grpBit   = (group > 5'(PROT_GROUP_TOP)) ? 5'(PROT_GROUP_TOP) : group;
  wire           writeOk  = effMask[grpBit];
  wire           readOk   = effMask[PROT_READ_BIT];

  // Command classes
  wire           isRead   = (code == CMD_READ);
  wire           isVerify = (code == CMD_VERIFY);
  wire           isWrite  = (code == CMD_WRITE);
  wire           isEraseW = (code == CMD_ERASE_WR);
  wire           isErase  = (code == CMD_ERASE_PG);
  wire           isMass   = (code == CMD_MASS);
  wire           isSign   = (code == CMD_SIGN);
  wire           isProt   = (code == CMD_PROTECT);
  wire           isPing   = (code == CMD_PING);
  wire           isArrMod = isWrite || isEraseW || isErase || isMass;
  wire           isValid  = isRead || isVerify || isArrMod || isSign || isProt || isPing;
  wire           keyOk    = (data_q == MASS_KEY_DATA) && (addr_q == MASS_KEY_ADDR);

  // Refusal of a valid command
  // Erase/write, mask, key and protect-once guards
  wire           refuse   = (isArrMod && !ewEn_q)
                          || ((isWrite || isEraseW || isErase) && !writeOk)
                          || ((isRead || isVerify) && !readOk)
                          || (isMass && !keyOk)
                          || (isProt && protUsed_q);

  // Walk ranges and the running code
  wire [14:0]    pageBase = {addr_q[15:9], 8'h00};
  wire [14:0]    pageEnd  = {addr_q[15:9], PAGE_LAST_OFS};
  wire           walkLast = (ptr_q == end_q);
  wire           runSign  = (cmd_q == CMD_SIGN);
  wire           runEw    = (cmd_q == CMD_ERASE_WR);

  // Timer load value and unit
  logic [31:0]   tmrCount;
  logic          tmrTick;
  wire           tmrExpired;
  always_comb begin
    tmrCount = PING_CYCLES;
    tmrTick  = 1'b0;
    if (isWrite || isProt) begin
      tmrCount = 32'(WRITE_TICKS);
      tmrTick  = 1'b1;
    end else if (isEraseW || isErase) begin
      tmrCount = 32'(ERASE_WRITE_US);
      tmrTick  = 1'b1;
    end else if (isMass) begin
      tmrCount = 32'(MASS_ERASE_US);
      tmrTick  = 1'b1;
    end else if (isSign) begin
      tmrCount = 32'(SIG_CYCLES);
    end else if (isRead || isVerify) begin
      tmrCount = READ_CYCLES;
    end
  end

  wire           start    = cmdWrite && isValid && !refuse;

  // Array port selection
  wire           walkOn   = (state_q == ST_WALK);
  wire           progNow  = (start && isWrite) || (walkOn && walkLast && runEw);
  wire           arrEn    = walkOn || (start && (isWrite || isRead || isVerify));
  wire           arrWe    = walkOn ? (!runSign && !(walkLast && runEw)) || progNow : progNow;
  wire [14:0]    arrAddr  = walkOn && !(walkLast && runEw) ? ptr_q : addr_q[15:1];
  wire [15:0]    arrWdata = progNow ? data_q : ERASED_WORD;
  wire [15:0]    arrRdata;

  fcc_array #(
    .ADDR_W (15),
    .DATA_W (16)
  ) u_array (
    .clock (clock),
    .en    (arrEn),
    .we    (arrWe),
    .addr  (arrAddr),
    .wdata (arrWdata),
    .rdata (arrRdata)
  );

  fcc_timer #(
    .CNT_W (32)
  ) u_timer (
    .clock   (clock),
    .nrst    (nrst),
    .load    (start),
    .useTick (tmrTick),
    .count   (tmrCount),
    .expired (tmrExpired)
  );

  // Read mux
  // Reserved bits zero
  wire [15:0]    statusWord = {12'h000, intFlag_q, !isIdle, fail_q, done_q};
  wire [7:0]     modeWord   = {3'b000, irqEn_q, ewEn_q, 1'b0, wsReq_q};
  logic [31:0]   rdMux;
  always_comb begin
    case (busReq.addr)
      OFS_STATUS:    rdMux = {16'h0000, statusWord};
      OFS_MODE:      rdMux = {24'h000000, modeWord};
      OFS_COMMAND:   rdMux = {24'h000000, cmd_q};
      OFS_DATA:      rdMux = {16'h0000, data_q};
      OFS_ADDRESS:   rdMux = {16'h0000, addr_q};
      OFS_SIGNATURE: rdMux = {8'h00, sig_q};
      OFS_PERSIST:   rdMux = persist_q;
      OFS_IMMED:     rdMux = immed_q;
      default:       rdMux = 32'h0000_0000;
    endcase
  end

  // Sequencer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start && (isEraseW || isErase || isMass || isSign)) begin
            state_q <= ST_WALK;
          end else if (start) begin
            state_q <= ST_WAIT;
          end else if (cmdWrite && isValid) begin
            state_q <= ST_DONE;
          end
        end
        ST_WALK:  state_q <= walkLast ? ST_WAIT : ST_WALK;
        ST_WAIT:  state_q <= tmrExpired ? ST_DONE : ST_WAIT;
        ST_DONE:  state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // Walk pointer and range
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ptr_q <= 15'h0000;
      end_q <= 15'h0000;
    end else if (start) begin
      ptr_q <= isMass ? KERNEL_END_WORD + 15'h0001 : (isSign ? 15'h0000 : pageBase);
      end_q <= (isMass || isSign) ? LAST_WORD : (isEraseW ? pageEnd + 15'h0001 : pageEnd);
    end else if (walkOn && !walkLast) begin
      ptr_q <= ptr_q + 15'h0001;
    end
  end

  // Command result and read-side capture
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      failPend_q <= 1'b0;
      rdPend_q   <= 1'b0;
      sigPend_q  <= 1'b0;
      sig_q      <= SIG_RST;
    end else begin
      rdPend_q  <= start && (isRead || isVerify);
      sigPend_q <= walkOn && runSign;
      if (cmdWrite && isValid) begin
        failPend_q <= refuse;
      end else if (rdPend_q && (cmd_q == CMD_VERIFY) && (arrRdata != data_q)) begin
        failPend_q <= 1'b1;
      end
      if (start && isSign) begin
        sig_q <= 24'h000000;
      end else if (sigPend_q) begin
        sig_q <= {sig_q[22:0], sig_q[23]} ^ {8'h00, arrRdata};
      end
    end
  end

  // Status flags, set wins over a clearing read
  wire           finish = (state_q == ST_DONE);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      done_q    <= 1'b0;
      fail_q    <= 1'b0;
      intFlag_q <= 1'b0;
    end else begin
      done_q    <= finish || (done_q && !rdStatus);
      fail_q    <= (finish && failPend_q) || (fail_q && !rdStatus);
      intFlag_q <= (finish && irqEn_q) || (intFlag_q && !rdStatus);
    end
  end

  // Command register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= CMD_NULL;
    end else if (cmdWrite && (code == CMD_NULL)) begin
      cmd_q <= CMD_READBACK;
    end else if (cmdWrite) begin
      cmd_q <= code;
    end else if (finish && (cmd_q <= CMD_MASS)) begin
      cmd_q <= CMD_READBACK;
    end
  end

  // Mode register and wait states
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqEn_q <= 1'b0;
      ewEn_q  <= 1'b0;
      wsReq_q <= WS_RST;
      ws_q    <= WS_RST;
    end else begin
      if (wrHit && (busReq.addr == OFS_MODE)) begin
        irqEn_q <= busReq.wdata[MOD_IRQ_EN];
        ewEn_q  <= busReq.wdata[MOD_EW_EN];
        wsReq_q <= busReq.wdata[MOD_WS_HI:0];
      end
      if (wsReq_q == peerWaitStates) begin
        ws_q <= wsReq_q;
      end
    end
  end

  // Data and address registers, bus writes ignored while busy
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_q <= DATA_RST;
      addr_q <= ADDR_RST;
    end else if (rdPend_q && (cmd_q == CMD_READ)) begin
      data_q <= arrRdata;
    end else if (wrHit && isIdle && (busReq.addr == OFS_DATA)) begin
      data_q <= busReq.wdata[15:0];
    end else if (wrHit && isIdle && (busReq.addr == OFS_ADDRESS)) begin
      addr_q <= busReq.wdata[15:0];
    end
  end

  // Protection masks set to reset values by nrst, mask in force then taken from saved_q
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      persist_q       <= PERSIST_RST;
      immed_q         <= IMMED_RST;
      persistAct_q    <= UNPROTECTED;
      persistLoaded_q <= 1'b0;
    end else begin
      if (!persistLoaded_q) begin
        persistAct_q    <= saved_q;
        persistLoaded_q <= 1'b1;
      end
      if (wrHit && (busReq.addr == OFS_PERSIST)) begin
        persist_q <= busReq.wdata;
      end
      if (wrHit && (busReq.addr == OFS_IMMED)) begin
        immed_q <= busReq.wdata;
      end
    end
  end

  // Saved mask, kept across nrst, cleared at power-on and by mass erase
  always_ff @(posedge clock or negedge powerOnN) begin
    if (!powerOnN) begin
      saved_q    <= UNPROTECTED;
      protUsed_q <= 1'b0;
    end else if (finish && !failPend_q && (cmd_q == CMD_PROTECT)) begin
      saved_q    <= persist_q;
      protUsed_q <= 1'b1;
    end else if (finish && !failPend_q && (cmd_q == CMD_MASS)) begin
      saved_q    <= UNPROTECTED;
      protUsed_q <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_q       <= 32'h0000_0000;
      irq_q         <= 1'b0;
      readAllowed_q <= 1'b0;
    end else begin
      rdata_q       <= busReq.re ? rdMux : 32'h0000_0000;
      irq_q         <= (finish && irqEn_q) || (intFlag_q && !rdStatus);
      readAllowed_q <= readOk;
    end
  end

  assign rdata       = rdata_q;
  assign irq         = irq_q;
  assign readAllowed = readAllowed_q;
  assign waitStates  = ws_q;

endmodule

// file: dv/fcc_checker_assertions.sv
/*
  Port checker for the flash command controller.
  Assumes fcc_pkg is compiled first and one clock domain.
*/
`timescale 1ns/10ps
module fcc_checker_assertions (
  // Clock and resets
  input wire logic                     clock,
  input wire logic                     nrst,
  input wire logic                     powerOnN,
  // Register port
  input wire fcc_pkg::fcc_bus_req_type busReq,
  input wire logic [31:0]              rdata,
  // System side
  input wire logic [1:0]               peerWaitStates,
  input wire logic [1:0]               waitStates,
  input wire logic                     irq,
  input wire logic                     readAllowed
);
  import fcc_pkg::*;
  // Decoded read strobes
  wire stRd = busReq.re && busReq.addr == OFS_STATUS;
  wire mdRd = busReq.re && busReq.addr == OFS_MODE;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!busReq.re |=> rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_status_rsvd: assert property (stRd |=> rdata[31:4] == 28'h0)
    else $error("reserved status bits not zero");
  a_mode_rsvd: assert property (mdRd |=> rdata[31:5] == 27'h0 && !rdata[2])
    else $error("reserved mode bits not zero");
  a_irq_status: assert property (stRd |=> rdata[3] == $past(irq))
    else $error("status interrupt bit differs from irq");
  a_int_has_done: assert property (stRd |=> !rdata[3] || rdata[0])
    else $error("interrupt flag without done flag");
  a_int_clear: assert property (stRd ##1 !rdata[2] |-> !irq)
    else $error("interrupt flag kept after status read");
  a_irq_fall: assert property ($fell(irq) |-> $past(stRd))
    else $error("irq dropped without status read");
  a_wait_follow: assert property ($changed(waitStates) |->
    waitStates == $past(peerWaitStates)) else $error("wait states changed without agreement");
  a_read_gate: assert property (
    busReq.we && busReq.addr == OFS_IMMED && !busReq.wdata[31] |-> ##2 !readAllowed)
    else $error("read allowed with mask bit 31 low");
endmodule
bind fcc_flash_command_controller fcc_checker_assertions u_chk (.clock(clock), .nrst(nrst),
  .powerOnN(powerOnN), .busReq(busReq), .rdata(rdata), .peerWaitStates(peerWaitStates),
  .waitStates(waitStates), .irq(irq), .readAllowed(readAllowed));

// file: dv/flash_command_controller_tb.sv
/*
  Register level testbench for the flash command controller.
  Assumes fcc_pkg and the design files are compiled first.
*/
`timescale 1ns/10ps
module flash_command_controller_tb;
  import fcc_pkg::*;
  logic clock, nrst, powerOnN, irq, readAllowed;
  logic [1:0] peerWaitStates, waitStates;
  logic [31:0] rdata, v;
  fcc_bus_req_type busReq;
  int num_errors, cmp_count, cycles;
  // Shortened erase timing
  fcc_flash_command_controller #(.ERASE_WRITE_US(5), .MASS_ERASE_US(5)) dut (.clock(clock),
    .nrst(nrst), .powerOnN(powerOnN), .busReq(busReq), .rdata(rdata),
    .peerWaitStates(peerWaitStates), .waitStates(waitStates), .irq(irq),
    .readAllowed(readAllowed));
  // Clock of 50 ns
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Cycle ceiling against hangs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 50000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", name, exp, got);
    end
  endtask
  // One cycle write strobe
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    busReq.we <= 1'b1;
    busReq.addr <= a;
    busReq.wdata <= d;
    @(posedge clock);
    busReq.we <= 1'b0;
  endtask
  // Read, data sampled in the following cycle
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    busReq.re <= 1'b1;
    busReq.addr <= a;
    @(posedge clock);
    busReq.re <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask
  task automatic rdchk(string name, logic [7:0] a, logic [31:0] exp);
    rd(a, v);
    chk(name, exp, v);
  endtask
  // Issue a command, poll busy, check final status
  task automatic cmd(logic [7:0] c, logic [31:0] exp);
    wr(OFS_COMMAND, {24'h0, c});
    rd(OFS_STATUS, v);
    for (int i = 0; i < 20000 && v[2] !== 1'b0; i++) rd(OFS_STATUS, v);
    chk("status", exp, v);
  endtask
  // Fetch one array word through the data register
  task automatic rdword(logic [15:0] a, logic [31:0] exp);
    wr(OFS_ADDRESS, {16'h0, a});
    cmd(CMD_READ, 32'h9);
    rdchk("word", OFS_DATA, exp);
  endtask
  initial begin
    busReq = '0;
    peerWaitStates = 2'h3;
    nrst = 1'b0;
    powerOnN = 1'b0;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    powerOnN <= 1'b1;
    rdchk("status", OFS_STATUS, 32'h0);
    rdchk("sign", OFS_SIGNATURE, 32'h00ff_ffff);
    rdchk("unmapped", 8'h40, 32'h0);
    wr(OFS_IMMED, 32'hffff_ffff);
    repeat (2) @(negedge clock);
    chk("readok", 32'h1, {31'h0, readAllowed});
    wr(OFS_MODE, 32'hfb);
    rdchk("mode", OFS_MODE, 32'h1b);
    chk("wait", 32'h3, {30'h0, waitStates});
    // Peer disagrees first, then agrees
    @(posedge clock);
    peerWaitStates <= 2'h1;
    wr(OFS_MODE, 32'h1a);
    repeat (2) @(negedge clock);
    chk("wait", 32'h3, {30'h0, waitStates});
    @(posedge clock);
    peerWaitStates <= 2'h2;
    repeat (2) @(negedge clock);
    chk("wait", 32'h2, {30'h0, waitStates});
    $display("test reset done");
    cmd(CMD_PING, 32'h9);
    rdchk("status", OFS_STATUS, 32'h0);
    rdchk("command", OFS_COMMAND, 32'h0f);
    wr(OFS_COMMAND, {24'h0, CMD_PING});
    repeat (6) @(negedge clock);
    chk("irq", 32'h1, {31'h0, irq});
    rdchk("status", OFS_STATUS, 32'h9);
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFS_COMMAND, {24'h0, CMD_NULL});
    rdchk("command", OFS_COMMAND, 32'h07);
    rdchk("status", OFS_STATUS, 32'h0);
    $display("test ping done");
    wr(OFS_DATA, 32'h1234);
    wr(OFS_ADDRESS, 32'h0100);
    cmd(CMD_WRITE, 32'h9);
    rdchk("command", OFS_COMMAND, 32'h07);
    wr(OFS_DATA, 32'h0);
    cmd(CMD_READ, 32'h9);
    rdchk("data", OFS_DATA, 32'h1234);
    cmd(CMD_VERIFY, 32'h9);
    wr(OFS_DATA, 32'h5555);
    cmd(CMD_VERIFY, 32'hb);
    wr(OFS_DATA, 32'h5a5a);
    wr(OFS_ADDRESS, 32'h1004);
    cmd(CMD_ERASE_WR, 32'h9);
    rdword(16'h1004, 32'h5a5a);
    rdword(16'h1000, 32'hffff);
    cmd(CMD_ERASE_PG, 32'h9);
    rdword(16'h1004, 32'hffff);
    $display("test array done");
    wr(OFS_MODE, 32'h03);
    cmd(CMD_WRITE, 32'h3);
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFS_COMMAND, 32'h0d);
    rdchk("status", OFS_STATUS, 32'h0);
    wr(OFS_IMMED, 32'h7fff_ffff);
    repeat (2) @(negedge clock);
    chk("readok", 32'h0, {31'h0, readAllowed});
    wr(OFS_MODE, 32'h1b);
    cmd(CMD_READ, 32'hb);
    $display("test guard done");
    wr(OFS_IMMED, 32'hffff_ffff);
    wr(OFS_PERSIST, 32'hffff_fffe);
    cmd(CMD_PROTECT, 32'h9);
    cmd(CMD_PROTECT, 32'hb);
    // Reset in mid-run: saved mask takes effect
    @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rdchk("immed", OFS_IMMED, 32'h0fff_ffff);
    chk("readok", 32'h0, {31'h0, readAllowed});
    wr(OFS_IMMED, 32'hffff_ffff);
    wr(OFS_MODE, 32'h1b);
    wr(OFS_ADDRESS, 32'h0100);
    cmd(CMD_WRITE, 32'hb);
    $display("test protect done");
    wr(OFS_DATA, 32'h3cff);
    wr(OFS_ADDRESS, 32'hffc3);
    cmd(CMD_MASS, 32'h9);
    rdword(16'h2000, 32'hffff);
    rdword(16'h0100, 32'h1234);
    $display("test mass erase done");
    close_out();
  end
endmodule
